// File: src/node_cfg_regs.v
/*
 analogue node configuration register bank with reset and mode control.
 assumes a configuration packet decoder that presents one read or write
 per cycle with a response request flag, and external reset sources that
 are asynchronous to ref_clk and pass through the pin synchronisers.
*/
`include "node_cfg_defs.vh"

module node_cfg_regs #(
   parameter [7:0]  CHIP_CODE       = 8'hA5,  // arbitrary value
   parameter [7:0]  BLOCK_REVISION  = 8'h11,  // arbitrary value
   parameter [7:0]  BLOCK_VERSION   = 8'h22,  // arbitrary value
   parameter        SYS_RST_CYCLES  = `SYS_RST_CYCLES,
   parameter        TILE_RST_CYCLES = `TILE_RST_CYCLES
) (
   input  wire        ref_clk,
   input  wire        rst_n,
   input  wire        cfg_req,
   input  wire        cfg_write,
   input  wire        cfg_resp_wanted,
   input  wire [7:0]  cfg_num,
   input  wire [31:0] cfg_wdata,
   output reg         cfg_resp,
   output reg         cfg_ack,
   output reg  [31:0] cfg_rdata,
   input  wire        oscillator_select_pin,
   input  wire        ext_reset_pin_n,
   input  wire        brownout_pin,
   input  wire        watchdog_expired,
   input  wire        sleep_sequence,
   input  wire        clock_source_change,
   output reg         system_reset,
   output reg         tile_reset,
   output reg         header_one_byte,
   output reg         usb_enable,
   output reg         usb_reset,
   output reg         usb_access_en,
   output reg  [1:0]  mode_pins_out,
   output reg  [1:0]  mode_pins_oe,
   output reg  [31:0] link_control_status_q,
   output reg  [31:0] oscillator_frequency_q,
   output reg  [31:0] watchdog_control_q,
   output reg  [31:0] watchdog_off_q
);

   localparam ST_RUN  = 2'b00;
   localparam ST_SYS  = 2'b01;
   localparam ST_TILE = 2'b10;

   reg  [2:0]  rst_pin_sync_q;
   reg  [2:0]  bo_sync_q;
   reg  [2:0]  osc_sync_q;
   reg         rst_pin_low_q;
   reg         bo_high_q;
   reg         osc_caught_q;
   reg         osc_seen_q;
   reg  [1:0]  osc_fill_q;
   reg  [1:0]  state_q;
   reg  [19:0] count_q;
   reg         lock_q;
   reg         hdr_q;
   reg  [15:0] number_q;
   reg         usb_en_q;
   reg         usb_acc_q;
   reg  [1:0]  mode_q;
   reg         mode_tri_q;
   wire        hw_sys_cause;
   wire        wr;
   wire        rm_wr;
   wire        sys_cause;
   wire        tile_cause;
   wire        sw_sys;
   wire        sw_tile;

   // two oldest synchroniser stages agree
   function stages_agree;
      input [2:0] stages;
      begin
         stages_agree = (stages[1] == stages[2]);
      end
   endfunction

   // register read path
   function [31:0] read_mux;
      input [7:0] num;
      begin
         read_mux = 32'h0000_0000;
         case (num)
            `REG_IDENTIFICATION:
            begin
               read_mux[`ID_CHIP_MSB:`ID_CHIP_LSB] = CHIP_CODE;
               read_mux[`ID_OSC_BIT]               = osc_caught_q;
               read_mux[`ID_REV_MSB:`ID_REV_LSB]   = BLOCK_REVISION;
               read_mux[`ID_VER_MSB:`ID_VER_LSB]   = BLOCK_VERSION;
            end
            `REG_NODE_SETUP:
            begin
               read_mux[`SETUP_LOCK_BIT] = lock_q;
               read_mux[`SETUP_HDR_BIT]  = hdr_q;
            end
            `REG_NODE_NUMBER:
               read_mux[`NUMBER_MSB:0] = number_q;
            `REG_RESET_AND_MODE:
            begin
               read_mux[`RM_USB_EN_BIT]                 = usb_en_q;
               read_mux[`RM_USB_ACC_BIT]                = usb_acc_q;
               read_mux[`RM_MODE_MSB:`RM_MODE_LSB]      = mode_q;
               read_mux[`RM_MODE_TRI_BIT]               = mode_tri_q;
            end
            `REG_OSCILLATOR_FREQUENCY:
               read_mux = oscillator_frequency_q;
            `REG_LINK_CONTROL_STATUS:
               read_mux = link_control_status_q;
            `REG_WATCHDOG_CONTROL:
               read_mux = watchdog_control_q;
            `REG_WATCHDOG_OFF:
               read_mux = watchdog_off_q;
            default:
               read_mux = 32'h0000_0000;
         endcase
      end
   endfunction

   // request qualifiers and reset causes
   assign wr         = cfg_req & cfg_write & (state_q == ST_RUN);
   assign rm_wr      = wr & (cfg_num == `REG_RESET_AND_MODE);
   assign sw_sys     = rm_wr & cfg_wdata[`RM_SYS_RST_BIT];
   assign sw_tile    = rm_wr & cfg_wdata[`RM_TILE_RST_BIT];
   assign hw_sys_cause = rst_pin_low_q | bo_high_q | watchdog_expired;
   assign sys_cause  = hw_sys_cause | sw_sys;
   assign tile_cause = sleep_sequence | clock_source_change | sw_tile;

   // pin synchronisers, change taken when stages two and three agree
   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rst_pin_sync_q <= 3'b111;
         bo_sync_q      <= 3'b000;
         osc_sync_q     <= 3'b000;
         rst_pin_low_q  <= 1'b0;
         bo_high_q      <= 1'b0;
      end
      else
      begin
         rst_pin_sync_q <= {rst_pin_sync_q[1:0], ext_reset_pin_n};
         bo_sync_q      <= {bo_sync_q[1:0], brownout_pin};
         osc_sync_q     <= {osc_sync_q[1:0], oscillator_select_pin};
         if (stages_agree(rst_pin_sync_q))
            rst_pin_low_q <= ~rst_pin_sync_q[2];
         if (stages_agree(bo_sync_q))
            bo_high_q <= bo_sync_q[2];
      end
   end

   // strap caught once after power-up
   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         osc_fill_q   <= 2'b00;
         osc_caught_q <= 1'b0;
         osc_seen_q   <= 1'b0;
      end
      else
      begin
         // let the pin reach the third stage first
         if (osc_fill_q != 2'b11)
            osc_fill_q <= osc_fill_q + 2'b01;
         if (!osc_seen_q && osc_fill_q == 2'b11 && stages_agree(osc_sync_q))
         begin
            osc_caught_q <= osc_sync_q[2];
            osc_seen_q   <= 1'b1;
         end
      end
   end

   // reset sequencer
   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_q      <= ST_SYS;
         count_q      <= 20'h00000;
         system_reset <= 1'b1;
         tile_reset   <= 1'b1;
      end
      else
      begin
         case (state_q)
            ST_RUN:
            begin
               count_q <= 20'h00000;
               if (sys_cause)
               begin
                  state_q      <= ST_SYS;
                  system_reset <= 1'b1;
                  tile_reset   <= 1'b1;
               end
               else if (tile_cause)
               begin
                  state_q    <= ST_TILE;
                  tile_reset <= 1'b1;
               end
            end
            ST_SYS:
            begin
               if (hw_sys_cause)
                  count_q <= 20'h00000;
               else if (count_q == SYS_RST_CYCLES[19:0] - 20'h00001)
               begin
                  state_q      <= ST_RUN;
                  system_reset <= 1'b0;
                  tile_reset   <= 1'b0;
               end
               else
                  count_q <= count_q + 20'h00001;
            end
            ST_TILE:
            begin
               if (sys_cause)
               begin
                  state_q      <= ST_SYS;
                  count_q      <= 20'h00000;
                  system_reset <= 1'b1;
               end
               else if (count_q == TILE_RST_CYCLES[19:0] - 20'h00001)
               begin
                  state_q    <= ST_RUN;
                  tile_reset <= 1'b0;
               end
               else
                  count_q <= count_q + 20'h00001;
            end
            default:
            begin
               state_q      <= ST_SYS;
               count_q      <= 20'h00000;
               system_reset <= 1'b1;
               tile_reset   <= 1'b1;
            end
         endcase
      end
   end

   // register bank, cleared by system reset too
   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         lock_q                 <= 1'b0;
         hdr_q                  <= 1'b0;
         number_q               <= 16'h0000;
         usb_en_q               <= 1'b0;
         usb_acc_q              <= 1'b0;
         mode_q                 <= 2'b00;
         mode_tri_q             <= 1'b0;
         link_control_status_q  <= `LINK_CTRL_RESET;
         oscillator_frequency_q <= `OSC_FREQ_RESET;
         watchdog_control_q     <= `WDOG_CTRL_RESET;
         watchdog_off_q         <= `WDOG_OFF_RESET;
      end
      else if (state_q == ST_SYS)
      begin
         lock_q                 <= 1'b0;
         hdr_q                  <= 1'b0;
         number_q               <= 16'h0000;
         usb_en_q               <= 1'b0;
         usb_acc_q              <= 1'b0;
         mode_q                 <= 2'b00;
         mode_tri_q             <= 1'b0;
         link_control_status_q  <= `LINK_CTRL_RESET;
         oscillator_frequency_q <= `OSC_FREQ_RESET;
         watchdog_control_q     <= `WDOG_CTRL_RESET;
         watchdog_off_q         <= `WDOG_OFF_RESET;
      end
      else if (wr)
      begin
         case (cfg_num)
            `REG_NODE_SETUP:
               if (!lock_q)
               begin
                  lock_q <= cfg_wdata[`SETUP_LOCK_BIT];
                  hdr_q  <= cfg_wdata[`SETUP_HDR_BIT];
               end
            `REG_NODE_NUMBER:
               number_q <= cfg_wdata[`NUMBER_MSB:0];
            `REG_RESET_AND_MODE:
            begin
               usb_en_q   <= cfg_wdata[`RM_USB_EN_BIT];
               usb_acc_q  <= cfg_wdata[`RM_USB_ACC_BIT];
               mode_q     <= cfg_wdata[`RM_MODE_MSB:`RM_MODE_LSB];
               mode_tri_q <= cfg_wdata[`RM_MODE_TRI_BIT];
            end
            `REG_OSCILLATOR_FREQUENCY:
               oscillator_frequency_q <= cfg_wdata & `OSC_FREQ_WMASK;
            `REG_LINK_CONTROL_STATUS:
               if (!lock_q)
                  link_control_status_q <= cfg_wdata & `LINK_CTRL_WMASK;
            `REG_WATCHDOG_CONTROL:
               watchdog_control_q <= cfg_wdata;
            `REG_WATCHDOG_OFF:
               watchdog_off_q <= cfg_wdata;
            default:
               lock_q <= lock_q;
         endcase
      end
   end

   // registered outputs and responses
   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cfg_resp        <= 1'b0;
         cfg_ack         <= 1'b0;
         cfg_rdata       <= 32'h0000_0000;
         header_one_byte <= 1'b0;
         usb_enable      <= 1'b0;
         usb_reset       <= 1'b1;
         usb_access_en   <= 1'b0;
         mode_pins_out   <= 2'b00;
         mode_pins_oe    <= 2'b00;
      end
      else
      begin
         cfg_resp  <= cfg_req & (state_q == ST_RUN) & (~cfg_write | cfg_resp_wanted)
                      & ~sw_sys & ~sw_tile;
         cfg_ack   <= ~cfg_write | (cfg_num != `REG_IDENTIFICATION);
         cfg_rdata <= cfg_write ? 32'h0000_0000 : read_mux(cfg_num);
         header_one_byte <= hdr_q;
         usb_enable      <= usb_en_q;
         usb_reset       <= ~usb_en_q;
         usb_access_en   <= usb_acc_q;
         mode_pins_out   <= mode_q;
         mode_pins_oe    <= {2{~mode_tri_q}};
      end
   end

endmodule

// File: pkg/node_cfg_defs.vh
/*
 constants for the analogue node configuration register bank:
 register numbers, field positions, reset values, timing counts.
 assumes inclusion by bare name from the design file.
*/
// Contract
// - the identification register is read-only and carries a chip code in 31:24, revision in 15:8 and version in 7:0.
// - identification bit 16 shows the oscillator-select pin caught at power-up, 0 crystal, 1 internal 20 MHz oscillator.
// - writing 1 to node setup bit 31 blocks all later writes to node setup and link control and status.
// - node setup bit 0 selects the header format, 0 three-byte and 1 one-byte, and resets to 0.
// - the node number register holds a 16-bit read-write identifier in 15:0 that resets to zero and is not relied on.
// - a system reset is raised by the external reset pin, a supply brown-out or watchdog expiry.
// - a sleep sequence or a clock source change raises only a processor-tile reset.
// - a system reset is held for a counter running 524,288 oscillator clock cycles.
// - writing 1 to reset and mode bit 0 starts a system reset and the bit clears itself.
// - a reset and mode write that sets either reset bit sends no response packet even if one was asked for.
// - writing 1 to reset and mode bit 1 starts a processor-tile reset only and the bit clears itself.
// - reset and mode bit 2 enables the USB block, clearing it disables and resets the USB registers, reset value 0.
// - reset and mode bit 3 gates USB peripheral register access, allowed only at 1, reset value 0.
// - reset and mode bits 17:16 drive the two processor mode pins and bit 24 tristates them.
// - a system reset resets the whole system including external devices, a tile reset only the processor tiles.
`ifndef NODE_CFG_DEFS_VH
`define NODE_CFG_DEFS_VH

`define REG_IDENTIFICATION        8'h00
`define REG_NODE_SETUP            8'h04
`define REG_NODE_NUMBER           8'h05
`define REG_RESET_AND_MODE        8'h50
`define REG_OSCILLATOR_FREQUENCY  8'h51
`define REG_LINK_CONTROL_STATUS   8'h80
`define REG_WATCHDOG_CONTROL      8'hD6
`define REG_WATCHDOG_OFF          8'hD7

`define ID_CHIP_MSB               31
`define ID_CHIP_LSB               24
`define ID_OSC_BIT                16
`define ID_REV_MSB                15
`define ID_REV_LSB                8
`define ID_VER_MSB                7
`define ID_VER_LSB                0

`define SETUP_LOCK_BIT            31
`define SETUP_HDR_BIT             0

`define NUMBER_MSB                15

`define RM_SYS_RST_BIT            0
`define RM_TILE_RST_BIT           1
`define RM_USB_EN_BIT             2
`define RM_USB_ACC_BIT            3
`define RM_MODE_LSB               16
`define RM_MODE_MSB               17
`define RM_MODE_TRI_BIT           24

`define SYS_RST_CYCLES            524288
`define TILE_RST_CYCLES           16
`define SYNC_STAGES               3

`define LINK_CTRL_RESET           32'h0000_0801
`define OSC_FREQ_RESET            32'h0000_0019
`define WDOG_CTRL_RESET           32'h0000_03E8
`define WDOG_OFF_RESET            32'h0D15_AB1E

`define LINK_CTRL_WMASK           32'hC03F_FFFF
`define OSC_FREQ_WMASK            32'h0000_007F

`endif

// File: verif/cfg_sender.sv
/* configuration packet sender: one access per call, held over the taking edge.
   assumes the bank answers on the edge that takes the request. */
module cfg_sender (
   input  wire         ref_clk,
   output logic        cfg_req,
   output logic        cfg_write,
   output logic        cfg_resp_wanted,
   output logic [7:0]  cfg_num,
   output logic [31:0] cfg_wdata,
   input  wire         cfg_resp,
   input  wire         cfg_ack,
   input  wire  [31:0] cfg_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      cfg_req = 0;
      cfg_write = 0;
      cfg_resp_wanted = 0;
      cfg_num = 8'hFF;
      cfg_wdata = 32'h0;
   end
   // drive on the falling edge, take the answer, then release with inverted lines
   task xfer(input w, input wn, input [7:0] n, input [31:0] d,
             output g, output a, output [31:0] r);
      @(negedge ref_clk);
      {cfg_req, cfg_write, cfg_resp_wanted, cfg_num, cfg_wdata} = {1'b1, w, wn, n, d};
      @(negedge ref_clk);
      {g, a, r} = {cfg_resp, cfg_ack, cfg_rdata};
      {cfg_req, cfg_num, cfg_wdata} = {1'b0, ~n, ~d};
   endtask
endmodule

// File: verif/node_cfg_regs_sva.sv
/* checker for the node register bank ports.
   assumes one clock domain and the async active-low power-on reset. */
module node_cfg_regs_sva #(
   parameter SYS_RST_CYCLES = 524288
) (
   input wire        ref_clk,
   input wire        rst_n,
   input wire        cfg_req,
   input wire        cfg_write,
   input wire        cfg_resp_wanted,
   input wire [7:0]  cfg_num,
   input wire [31:0] cfg_wdata,
   input wire        cfg_resp,
   input wire        cfg_ack,
   input wire [31:0] cfg_rdata,
   input wire        oscillator_select_pin,
   input wire        ext_reset_pin_n,
   input wire        brownout_pin,
   input wire        watchdog_expired,
   input wire        sleep_sequence,
   input wire        clock_source_change,
   input wire        system_reset,
   input wire        tile_reset,
   input wire        header_one_byte,
   input wire        usb_enable,
   input wire        usb_reset,
   input wire [31:0] link_control_status_q
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   wire         run   = !system_reset && !tile_reset;
   wire         wr_rm = cfg_req && cfg_write && cfg_num == 8'h50 && run;
   logic        lock_q, lock_dly1_q, lock_dly2_q;
   logic [31:0] sys_cnt_q;
   // mirror of the update lock, cleared by system reset
   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         {lock_q, lock_dly1_q, lock_dly2_q, sys_cnt_q} <= 35'h0;
      else
      begin
         lock_q      <= !system_reset && (lock_q || (cfg_req && cfg_write && run
                        && cfg_num == 8'h04 && cfg_wdata[31]));
         lock_dly1_q <= lock_q;
         lock_dly2_q <= lock_dly1_q;
         sys_cnt_q   <= system_reset ? sys_cnt_q + 32'h1 : 32'h0;
      end
   end
   a_id_nack: assert property (cfg_req && cfg_write && cfg_resp_wanted && run
      && cfg_num == 8'h00 |=> cfg_resp && !cfg_ack) else $error("id write not nacked");
   a_osc_strap: assert property (cfg_resp && $past(cfg_req && !cfg_write && cfg_num == 8'h00)
      |-> cfg_rdata[23:16] == {7'h0, oscillator_select_pin}) else $error("id strap bits");
   a_lock_hold: assert property (lock_dly2_q && !system_reset
      |-> $stable(header_one_byte) && $stable(link_control_status_q)) else $error("locked change");
   a_rst_silent: assert property (wr_rm && cfg_wdata[1:0] != 2'b00 |=> !cfg_resp)
      else $error("response after reset write");
   a_sys_start: assert property (wr_rm && cfg_wdata[0] |=> system_reset && tile_reset)
      else $error("software system reset missing");
   a_tile_start: assert property (wr_rm && cfg_wdata[1:0] == 2'b10
      |=> tile_reset && !system_reset ##1 tile_reset) else $error("tile reset wrong");
   a_tile_under_sys: assert property (system_reset |-> tile_reset)
      else $error("tile not reset with system");
   a_sys_length: assert property ($fell(system_reset) |-> sys_cnt_q >= SYS_RST_CYCLES - 1)
      else $error("system reset too short");
   a_usb_pair: assert property (usb_reset != usb_enable) else $error("usb reset mismatch");
   a_tile_only: assert property ((sleep_sequence || clock_source_change) && run
      && !watchdog_expired && ext_reset_pin_n && !brownout_pin
      |-> ##[1:4] (tile_reset && !system_reset)) else $error("tile cause wrong");
   a_wdog_rst: assert property (watchdog_expired |-> ##[1:4] system_reset)
      else $error("watchdog reset missing");
   a_pin_rst: assert property (!ext_reset_pin_n || brownout_pin |-> ##[1:8] system_reset)
      else $error("pin reset missing");
   c_sys_end: cover property ($fell(system_reset));
   c_tile_wr: cover property (wr_rm && cfg_wdata[1]);
   c_nack: cover property (cfg_resp && !cfg_ack);
endmodule

bind node_cfg_regs node_cfg_regs_sva #(.SYS_RST_CYCLES(SYS_RST_CYCLES)) u_sva (
   .ref_clk(ref_clk), .rst_n(rst_n), .cfg_req(cfg_req), .cfg_write(cfg_write),
   .cfg_resp_wanted(cfg_resp_wanted), .cfg_num(cfg_num), .cfg_wdata(cfg_wdata),
   .cfg_resp(cfg_resp), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata),
   .oscillator_select_pin(oscillator_select_pin), .ext_reset_pin_n(ext_reset_pin_n),
   .brownout_pin(brownout_pin), .watchdog_expired(watchdog_expired),
   .sleep_sequence(sleep_sequence), .clock_source_change(clock_source_change),
   .system_reset(system_reset), .tile_reset(tile_reset), .header_one_byte(header_one_byte),
   .usb_enable(usb_enable), .usb_reset(usb_reset),
   .link_control_status_q(link_control_status_q));

// File: verif/node_cfg_regs_test.sv
/* bench for the node register bank: scenario tasks, checks and verdict.
   assumes cfg_sender on the packet side and the oscillator strap tied high. */
module node_cfg_regs_test;
   timeunit 1ns;
   timeprecision 1ps;
   localparam [31:0] ID = 32'hA501_1122;
   logic        ref_clk, rst_n, ext_n, bo, wdog, slp, csc, g, a;
   logic [31:0] r;
   wire         cfg_req, cfg_write, cfg_resp_wanted, cfg_resp, cfg_ack, system_reset;
   wire         tile_reset, header_one_byte, usb_enable, usb_reset, usb_access_en;
   wire  [7:0]  cfg_num;
   wire  [31:0] cfg_wdata, cfg_rdata, lcs, ofq, wdc, wdo;
   wire  [1:0]  mo, moe;
   int          miscompares = 0;
   int          comparisons = 0;
   cfg_sender snd (.ref_clk(ref_clk), .cfg_req(cfg_req), .cfg_write(cfg_write),
      .cfg_resp_wanted(cfg_resp_wanted), .cfg_num(cfg_num), .cfg_wdata(cfg_wdata),
      .cfg_resp(cfg_resp), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata));
   node_cfg_regs #(.CHIP_CODE(8'hA5), .BLOCK_REVISION(8'h11), .BLOCK_VERSION(8'h22),
      .SYS_RST_CYCLES(64)) DUT (.ref_clk(ref_clk), .rst_n(rst_n), .cfg_req(cfg_req),
      .cfg_write(cfg_write), .cfg_resp_wanted(cfg_resp_wanted), .cfg_num(cfg_num),
      .cfg_wdata(cfg_wdata), .cfg_resp(cfg_resp), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata),
      .oscillator_select_pin(1'b1), .ext_reset_pin_n(ext_n), .brownout_pin(bo),
      .watchdog_expired(wdog), .sleep_sequence(slp), .clock_source_change(csc),
      .system_reset(system_reset), .tile_reset(tile_reset), .header_one_byte(header_one_byte),
      .usb_enable(usb_enable), .usb_reset(usb_reset), .usb_access_en(usb_access_en),
      .mode_pins_out(mo), .mode_pins_oe(moe), .link_control_status_q(lcs),
      .oscillator_frequency_q(ofq), .watchdog_control_q(wdc), .watchdog_off_q(wdo));
   initial
   begin
      ref_clk = 0;
      forever #2 ref_clk = ~ref_clk;
   end
   task summarize;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task chk(input string n, input logic [31:0] e, input logic [31:0] s);
      comparisons++;
      if (s !== e)
      begin
         miscompares++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask
   task rd(input [7:0] n, input [31:0] e);
      snd.xfer(1'b0, 1'b1, n, 32'h0, g, a, r);
      chk("rd_resp", 1, g);
      chk("rd_ack", 1, a);
      chk("rd_data", e, r);
   endtask
   task wr(input [7:0] n, input [31:0] d, input ea);
      snd.xfer(1'b1, 1'b1, n, d, g, a, r);
      chk("wr_resp", 1, g);
      chk("wr_ack", ea, a);
   endtask
   task wait_run;
      int i;
      for (i = 0; i < 300 && (system_reset !== 1'b0 || tile_reset !== 1'b0); i++)
         @(negedge ref_clk);
      if (i == 300)
      begin
         chk("run_timeout", 0, 1);
         summarize();
      end
   endtask
   task t_ident;
      rd(8'h00, ID);
      wr(8'h00, 32'hFFFF_FFFF, 0);
      rd(8'h00, ID);
   endtask
   task t_number;
      rd(8'h05, 32'h0);
      rd(8'h50, 32'h0);
      chk("usb_reset", 1, usb_reset);
      wr(8'h05, 32'hFFFF_FFFF, 1);
      rd(8'h05, 32'h0000_FFFF);
      wr(8'h33, 32'hFFFF_FFFF, 1);
      rd(8'h33, 32'h0);
      rd(8'h51, 32'h0000_0019);
      wr(8'h51, 32'hFFFF_FFFF, 1);
      rd(8'h51, 32'h0000_007F);
      chk("osc_freq_q", 32'h0000_007F, ofq);
   endtask
   task t_mode;
      wr(8'h50, 32'hFFFF_FFFC, 1);
      rd(8'h50, 32'h0103_000C);
      chk("usb_on", 2'b10, {usb_enable, usb_reset});
      chk("usb_access", 1, usb_access_en);
      chk("mode_tri", 4'hC, {mo, moe});
      wr(8'h50, 32'h0002_0000, 1);
      rd(8'h50, 32'h0002_0000);
      chk("usb_off", 3'b010, {usb_enable, usb_reset, usb_access_en});
      chk("mode_drive", 4'hB, {mo, moe});
   endtask
   task t_lock;
      wr(8'h04, 32'h7FFF_FFFF, 1);
      rd(8'h04, 32'h1);
      chk("header", 1, header_one_byte);
      wr(8'h80, 32'h3, 1);
      rd(8'h80, 32'h3);
      wr(8'h04, 32'h8000_0001, 1);
      wr(8'h04, 32'h0, 1);
      rd(8'h04, 32'h8000_0001);
      wr(8'h80, 32'h5, 1);
      rd(8'h80, 32'h3);
      chk("link_q", 32'h3, lcs);
      chk("header_locked", 1, header_one_byte);
   endtask
   task t_tile(input int k);
      int i;
      if (k == 0)
         snd.xfer(1'b1, 1'b1, 8'h50, 32'h0002_0002, g, a, r);
      if (k == 0)
         chk("tile_wr_resp", 0, g);
      slp = (k == 1);
      csc = (k == 2);
      @(negedge ref_clk);
      {slp, csc} = 2'b00;
      for (i = 0; i < 8 && tile_reset !== 1'b1; i++)
         @(negedge ref_clk);
      chk("tile_reset", 1, tile_reset);
      chk("sys_quiet", 0, system_reset);
      wait_run();
      rd(8'h04, 32'h8000_0001);
      rd(8'h50, 32'h0002_0000);
   endtask
   task t_sys(input int k);
      int i;
      int n;
      wr(8'h04, 32'h8000_0001, 1);
      wr(8'h05, 32'h0000_1234, 1);
      wr(8'h50, 32'h0000_000C, 1);
      wr(8'hD6, 32'h0000_0005, 1);
      wr(8'hD7, 32'h0000_0000, 1);
      if (k == 0)
         snd.xfer(1'b1, 1'b1, 8'h50, 32'h0000_0001, g, a, r);
      if (k == 0)
         chk("sys_wr_resp", 0, g);
      {wdog, ext_n, bo} = {k == 1, k != 2, k == 3};
      repeat (k == 0 ? 0 : 4) @(negedge ref_clk);
      {wdog, ext_n, bo} = 3'b010;
      for (i = 0; i < 8 && system_reset !== 1'b1; i++)
         @(negedge ref_clk);
      chk("sys_reset", 1, system_reset);
      chk("tile_in_sys", 1, tile_reset);
      for (n = 0; n < 200 && system_reset === 1'b1; n++)
         @(negedge ref_clk);
      chk("sys_len_ok", 1, n >= 60 && n <= 80);
      wait_run();
      rd(8'h04, 32'h0);
      rd(8'h05, 32'h0);
      rd(8'h50, 32'h0);
      chk("usb_reset", 1, usb_reset);
      rd(8'h51, 32'h0000_0019);
      rd(8'hD6, 32'h0000_03E8);
      rd(8'hD7, 32'h0D15_AB1E);
      chk("wdog_ctrl_q", 32'h0000_03E8, wdc);
      chk("wdog_off_q", 32'h0D15_AB1E, wdo);
   endtask
   initial
   begin
      {rst_n, ext_n, bo, wdog, slp, csc} = 6'b010000;
      repeat (8) @(negedge ref_clk);
      rst_n = 1;
      wait_run();
      t_ident();
      t_number();
      t_mode();
      t_lock();
      for (int k = 0; k < 3; k++) t_tile(k);
      for (int k = 0; k < 4; k++) t_sys(k);
      summarize();
   end
endmodule
